// ---- bench/ext_party.sv ----
`timescale 1ns/10ps
module ext_party (
    input wire logic clk_i, // Phase clock
    input wire logic core_run_i, // Core may advance
    input wire logic bus_granted_i, // Device has released the buses
    output logic instr_done_o, // Instruction boundary
    output logic [15:0] next_addr_o, // Next instruction address
    output logic reset_n_o, // Device reset pin
    output logic nmi_n_o, // Non-maskable pin
    output logic halt_n_o, // Stop request pin
    output logic mode_pin_low_o, // Strap low
    output logic mode_pin_high_o, // Strap high
    output logic low_address_strobe_o // Address strobe
);
    logic [1:0] cnt_r;
    initial begin
        reset_n_o = 1'b0;
        nmi_n_o = 1'b1;
        halt_n_o = 1'b1;
        mode_pin_low_o = 1'b0;
        mode_pin_high_o = 1'b1;
        low_address_strobe_o = 1'b0;
        cnt_r = 2'h0;
        next_addr_o = 16'h0100;
    end
    // Boundary decoded from the counter register keeps the core loop free of combinational paths
    assign instr_done_o = (cnt_r == 2'h3);
    always @(posedge clk_i) begin
        // Strobe parked low while another master may own the buses
        low_address_strobe_o <= bus_granted_i ? 1'b0 : ~low_address_strobe_o;
        if (core_run_i) begin
            cnt_r <= cnt_r + 2'h1;
            if (instr_done_o) next_addr_o <= next_addr_o + 16'h1;
        end
    end
    task dev_reset(input logic hi, input logic lo);
        @(posedge clk_i);
        reset_n_o <= 1'b0;
        mode_pin_high_o <= hi;
        mode_pin_low_o <= lo;
        repeat (4) @(posedge clk_i);
        reset_n_o <= 1'b1;
    endtask : dev_reset
    task nmi_pulse;
        @(posedge clk_i);
        nmi_n_o <= 1'b0;
        repeat (3) @(posedge clk_i);
        nmi_n_o <= 1'b1;
    endtask : nmi_pulse
    task halt_set(input logic v);
        @(posedge clk_i);
        halt_n_o <= v;
    endtask : halt_set
    task step;
        @(posedge clk_i);
        halt_n_o <= 1'b1;
        @(posedge clk_i);
        halt_n_o <= 1'b0;
    endtask : step
endmodule : ext_party

// ---- bench/ihrc_properties.sv ----
`timescale 1ns/10ps
module ihrc_checker (
    input wire logic clk_i, // Clock
    input wire logic rst_i, // Sync reset
    input wire logic instr_write_i, // Core writing
    input wire logic [15:0] next_addr_i, // Next address
    input wire logic [15:0] bus_addr_i, // Bus address
    input wire logic wb_cyc_i, // Cycle
    input wire logic wb_stb_i, // Strobe
    input wire logic wb_ack_o, // Ack
    input wire logic wb_err_o, // Error
    input wire logic core_run_o, // Core advances
    input wire logic core_stack_o, // Stack push
    input wire logic vec_fetch_o, // Vector fetch
    input wire logic [15:0] vec_addr_o, // Vector address
    input wire logic [15:0] addr_o, // Address bus
    input wire logic rw_o, // Direction
    input wire logic bus_granted_o, // Bus available
    input wire logic internal_reg_sel_o, // Register area hit
    input wire logic [1:0] mode_o, // Latched mode
    input wire logic mode_bad_o, // Mode not allowed
    input wire logic reset_active_o // Device reset in progress
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    // Device reset parks the sequencer on the reset vector high byte, so it is excluded too
    default disable iff (rst_i || reset_active_o);
    a_reg_area_sel: assert property (!bus_granted_o && bus_addr_i[15:5] != 11'h0 |-> !internal_reg_sel_o)
        else $error("register area select outside low 32");
    a_reg_area_hit: assert property (addr_o[15:4] == 12'h001 |-> internal_reg_sel_o)
        else $error("register area upper half not selected");
    a_halt_outputs: assert property (bus_granted_o |-> rw_o && addr_o == next_addr_i)
        else $error("halt outputs wrong");
    a_stack_writes: assert property (core_stack_o |-> !rw_o && !bus_granted_o)
        else $error("stacking without write direction");
    a_core_write: assert property (core_run_o && instr_write_i && !vec_fetch_o |-> !rw_o)
        else $error("core write shows read direction");
    a_vec_read: assert property (vec_fetch_o |-> rw_o && vec_addr_o[15:4] == 12'hfff)
        else $error("vector fetch outside table or not read");
    a_vec_pair: assert property (vec_fetch_o && !vec_addr_o[0] |=>
        vec_fetch_o && vec_addr_o == ($past(vec_addr_o) | 16'h1))
        else $error("vector low byte not after high byte");
    a_stack_len: assert property ($rose(core_stack_o) |-> core_stack_o [*7] ##1 (vec_fetch_o && !vec_addr_o[0]))
        else $error("stacking length or vector order wrong");
    a_mode_check: assert property (mode_bad_o == !mode_o[1])
        else $error("mode flag disagrees with mode");
    a_wb_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o ^ wb_err_o)
        else $error("bus request not answered in one cycle");
endmodule : ihrc_checker

bind interrupt_halt_reset_control ihrc_checker chk (.clk_i, .rst_i, .instr_write_i, .next_addr_i, .bus_addr_i,
    .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_err_o, .core_run_o, .core_stack_o, .vec_fetch_o, .vec_addr_o, .addr_o,
    .rw_o, .bus_granted_o, .internal_reg_sel_o, .mode_o, .mode_bad_o, .reset_active_o);

// ---- bench/test_interrupt_halt_reset_control.sv ----
`timescale 1ns/10ps
`include "exc_cfg.svh"
module test_interrupt_halt_reset_control;
    logic clk_i, rst_i, ce_i, reset_n_i, nmi_n_i, external_int_request_n_i, halt_n_i, mode_pin_low_i, mode_pin_high_i;
    logic low_address_strobe_i, instr_done_i, instr_write_i, software_trap_i, wb_we_i, wb_cyc_i, wb_stb_i, er;
    logic capture_event_flag_i, compare_match_flag_i, counter_wrap_flag_i;
    logic receive_full_flag_i, overrun_framing_flag_i, transmit_empty_flag_i;
    logic [15:0] next_addr_i, bus_addr_i, vec_addr_o, addr_o, v, a;
    logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, rd;
    logic [3:0] wb_sel_i;
    logic [5:0] flags;
    logic wb_ack_o, wb_err_o, core_run_o, core_stack_o, vec_fetch_o, rw_o, bus_granted_o, internal_reg_sel_o;
    logic internal_int_request_o, mode_bad_o, reset_active_o, as_seen_o;
    logic [1:0] mode_o;
    int err_total = 0, tests_run = 0, cycles = 0;
    assign {capture_event_flag_i, compare_match_flag_i, counter_wrap_flag_i} = flags[5:3];
    assign {receive_full_flag_i, overrun_framing_flag_i, transmit_empty_flag_i} = flags[2:0];
    assign bus_addr_i = next_addr_i - 16'h00f0;
    interrupt_halt_reset_control uut (.clk_i, .rst_i, .ce_i, .reset_n_i, .nmi_n_i, .external_int_request_n_i,
        .halt_n_i, .mode_pin_low_i, .mode_pin_high_i, .low_address_strobe_i, .instr_done_i, .instr_write_i,
        .next_addr_i, .bus_addr_i, .software_trap_i, .capture_event_flag_i, .compare_match_flag_i,
        .counter_wrap_flag_i, .receive_full_flag_i, .overrun_framing_flag_i, .transmit_empty_flag_i, .wb_adr_i,
        .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .core_run_o,
        .core_stack_o, .vec_fetch_o, .vec_addr_o, .addr_o, .rw_o, .bus_granted_o, .internal_reg_sel_o,
        .internal_int_request_o, .mode_o, .mode_bad_o, .reset_active_o, .as_seen_o);
    ext_party pm (.clk_i, .core_run_i(core_run_o), .bus_granted_i(bus_granted_o), .instr_done_o(instr_done_i),
        .next_addr_o(next_addr_i),
        .reset_n_o(reset_n_i), .nmi_n_o(nmi_n_i), .halt_n_o(halt_n_i), .mode_pin_low_o(mode_pin_low_i),
        .mode_pin_high_o(mode_pin_high_i), .low_address_strobe_o(low_address_strobe_i));
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    // Whole run needs several hundred cycles; the ceiling leaves ample margin
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total++;
            end_sim();
        end
    end
    task end_sim;
        $display("checks=%0d mismatches=%0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_sim
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task wb(input logic [7:0] ad, input logic w, input logic [31:0] d);
        @(posedge clk_i);
        wb_adr_i <= {24'h0, ad};
        wb_we_i <= w;
        wb_dat_i <= d;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
        rd = wb_dat_o;
        er = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb
    task wait_vec;
        for (int n = 0; n < 200 && vec_fetch_o !== 1'b1; n++) @(posedge clk_i);
        v = vec_addr_o;
    endtask : wait_vec
    task no_vec;
        logic hit;
        hit = 1'b0;
        repeat (60) begin
            @(posedge clk_i);
            if (vec_fetch_o !== 1'b0) hit = 1'b1;
        end
        chk(hit, 1'b0);
    endtask : no_vec
    task fire(input logic [7:0] c);
        @(posedge clk_i);
        software_trap_i <= c[7];
        external_int_request_n_i <= ~c[6];
        // The pin passes two flops; flags wait so both reach the priority logic together
        repeat (2) @(posedge clk_i);
        flags <= c[5:0];
    endtask : fire
    task t_mode;
        logic [1:0] s [3] = '{2'b01, 2'b11, 2'b10};
        for (int i = 0; i < 3; i++) begin
            pm.dev_reset(s[i][1], s[i][0]);
            chk(reset_active_o, 1'b1);
            wait_vec();
            chk(v, `VEC_RESET);
            repeat (20) @(posedge clk_i);
            chk(reset_active_o, 1'b0);
            chk(mode_o, s[i]);
            chk(mode_bad_o, !s[i][1]);
        end
        wb(`CTRL_OFF, 1'b0, 32'h0);
        chk(rd[7:0], `CTRL_RESET);
        wb(8'h40, 1'b0, 32'h0);
        chk(er, 1'b1);
        wb(`STATUS_OFF, 1'b1, 32'hff);
        wb(`STATUS_OFF, 1'b0, 32'h0);
        chk(rd[1:0], `MODE_RAM);
    endtask : t_mode
    task t_vec;
        logic [7:0] c [8] = '{8'h80, 8'h41, 8'h3f, 8'h18, 8'h0c, 8'h04, 8'h02, 8'h01};
        logic [15:0] e [8] = '{`VEC_TRAP, `VEC_EXT, `VEC_CAP, `VEC_CMP, `VEC_WRAP, `VEC_SER, `VEC_SER, `VEC_SER};
        for (int i = 0; i < 8; i++) begin
            wb(`CTRL_OFF, 1'b1, 32'h1e);
            fire(c[i]);
            wait_vec();
            chk(v, e[i]);
            fire(8'h0);
            wb(`CTRL_OFF, 1'b0, 32'h0);
            chk(rd[0], 1'b1);
        end
    endtask : t_vec
    task t_mask;
        fire(8'h20);
        wb(`CTRL_OFF, 1'b1, 32'h1f);
        no_vec();
        chk(internal_int_request_o, 1'b1);
        wb(`CTRL_OFF, 1'b1, 32'h00);
        no_vec();
        chk(internal_int_request_o, 1'b0);
        wb(`CTRL_OFF, 1'b1, 32'h1f);
        pm.nmi_pulse();
        wait_vec();
        chk(v, `VEC_NMI);
        fire(8'h0);
    endtask : t_mask
    task t_halt;
        pm.halt_set(1'b0);
        for (int n = 0; n < 100 && bus_granted_o !== 1'b1; n++) @(posedge clk_i);
        chk(bus_granted_o, 1'b1);
        chk(rw_o, 1'b1);
        chk(addr_o, next_addr_i);
        repeat (4) @(posedge clk_i);
        chk(as_seen_o, 1'b0);
        a = next_addr_i;
        pm.step();
        for (int n = 0; n < 50 && bus_granted_o !== 1'b0; n++) @(posedge clk_i);
        for (int n = 0; n < 50 && bus_granted_o !== 1'b1; n++) @(posedge clk_i);
        chk(next_addr_i, a + 16'h1);
        wb(`STEP_OFF, 1'b1, 32'h1);
        for (int n = 0; n < 50 && bus_granted_o !== 1'b0; n++) @(posedge clk_i);
        for (int n = 0; n < 50 && bus_granted_o !== 1'b1; n++) @(posedge clk_i);
        chk(next_addr_i, a + 16'h2);
        pm.halt_set(1'b1);
        instr_write_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        instr_write_i <= 1'b0;
    endtask : t_halt
    initial begin
        rst_i = 1'b1;
        ce_i = 1'b1;
        external_int_request_n_i = 1'b1;
        software_trap_i = 1'b0;
        instr_write_i = 1'b0;
        flags = 6'h0;
        wb_adr_i = 32'h0;
        wb_dat_i = 32'h0;
        wb_sel_i = 4'h1;
        wb_we_i = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        t_mode();
        t_vec();
        t_mask();
        t_halt();
        end_sim();
    end
endmodule : test_interrupt_halt_reset_control

// ---- design/exc_cfg.svh ----
`ifndef EXC_CFG_SVH
`define EXC_CFG_SVH
// Register bus offsets (byte addresses, one word each)
`define CTRL_OFF 8'h00
`define STATUS_OFF 8'h04
`define STEP_OFF 8'h08
`define VECTOR_OFF 8'h0c
// Control register fields
`define CTRL_MASK_BIT 0
`define CTRL_EN_CAP_BIT 1
`define CTRL_EN_CMP_BIT 2
`define CTRL_EN_WRAP_BIT 3
`define CTRL_EN_SER_BIT 4
`define CTRL_RESET 8'h01
// Vector addresses (high byte location)
`define VEC_RESET 16'hfffe
`define VEC_NMI 16'hfffc
`define VEC_TRAP 16'hfffa
`define VEC_EXT 16'hfff8
`define VEC_CAP 16'hfff6
`define VEC_CMP 16'hfff4
`define VEC_WRAP 16'hfff2
`define VEC_SER 16'hfff0
// Internal register area
`define REG_AREA_SIZE 32
// Modes
`define MODE_RAM 2'b10
`define MODE_NORAM 2'b11
// Stacking: PCL PCH XL XH A B CCR, seven bytes; vector fetch two bytes
`define STACK_BYTES 3'd7
`define RESET_MIN_CYCLES 3
`endif

// ---- design/exc_pkg.sv ----
package exc_pkg;
    typedef enum logic [2:0] {
        ST_RUN = 3'b000,
        ST_STACK = 3'b001,
        ST_VEC_HI = 3'b010,
        ST_VEC_LO = 3'b011,
        ST_HALT = 3'b100
    } seq_state_t;
    typedef enum logic [2:0] {
        SRC_NONE = 3'b000,
        SRC_NMI = 3'b001,
        SRC_TRAP = 3'b010,
        SRC_EXT = 3'b011,
        SRC_CAP = 3'b100,
        SRC_CMP = 3'b101,
        SRC_WRAP = 3'b110,
        SRC_SER = 3'b111
    } src_t;
endpackage : exc_pkg

// ---- design/interrupt_halt_reset_control.sv ----
// Decided for this implementation: the address map and register access over Wishbone.
`timescale 1ns/10ps
`include "exc_cfg.svh"
// Functional notes
// - Lowest 32 addresses are internal registers, except 04-07 and 0F
// - Pending non-maskable request always serviced after instruction; a low stop request at the boundary halts first instead
// - Mask bit gates maskables; per-source enables gate internal ones
// - External maskable beats internal maskable
// - Four internal sources, fixed priority, own vectors
// - Vectors fetched high byte first, fixed table
// - Any serial condition takes serial vector
// - Stack PC, accumulators, CCR; set mask; vector (mask is set on entry, before stacking)
// - Stop request low: halt, direction high, next address
// - Single step: one-cycle release runs one instruction
// - Bus granted high while stopped
// - Direction low on write, high on read
// - Mode captured on reset rising edge
// - Non-maskable falling edge, vector FFFC
// - External maskable level sensitive, vector FFF8
// - Mode 2 with RAM, mode 3 without
module interrupt_halt_reset_control
    import exc_pkg::*;
(
    input wire logic clk_i, // Phase clock, 200 MHz model
    input wire logic rst_i, // Synchronous reset, active high
    input wire logic ce_i, // Clock enable
    input wire logic reset_n_i, // Device reset pin, async
    input wire logic nmi_n_i, // Non-maskable request pin, async
    input wire logic external_int_request_n_i, // External maskable request, async
    input wire logic halt_n_i, // Stop request pin, async
    input wire logic mode_pin_low_i, // Mode strap low, async
    input wire logic mode_pin_high_i, // Mode strap high, async
    input wire logic low_address_strobe_i, // Address strobe, async
    input wire logic instr_done_i, // Core: instruction boundary reached
    input wire logic instr_write_i, // Core: current cycle writes
    input wire logic [15:0] next_addr_i, // Core: address of next instruction
    input wire logic [15:0] bus_addr_i, // Core: current bus address
    input wire logic software_trap_i, // Core: trap instruction executing
    input wire logic capture_event_flag_i, // Timer capture flag
    input wire logic compare_match_flag_i, // Timer compare flag
    input wire logic counter_wrap_flag_i, // Timer wrap flag
    input wire logic receive_full_flag_i, // Serial receive full
    input wire logic overrun_framing_flag_i, // Serial error
    input wire logic transmit_empty_flag_i, // Serial transmit empty
    input wire logic [31:0] wb_adr_i, // Wishbone address
    input wire logic [31:0] wb_dat_i, // Wishbone write data
    input wire logic [3:0] wb_sel_i, // Wishbone byte selects
    input wire logic wb_we_i, // Wishbone write
    input wire logic wb_cyc_i, // Wishbone cycle
    input wire logic wb_stb_i, // Wishbone strobe
    output logic [31:0] wb_dat_o, // Wishbone read data
    output logic wb_ack_o, // Wishbone ack
    output logic wb_err_o, // Wishbone error on unmapped
    output logic core_run_o, // Core may advance
    output logic core_stack_o, // Core pushes one stack byte
    output logic vec_fetch_o, // Vector byte fetch cycle
    output logic [15:0] vec_addr_o, // Vector byte address
    output logic [15:0] addr_o, // Address bus
    output logic rw_o, // Direction: high read, low write
    output logic bus_granted_o, // Bus available to other masters
    output logic internal_reg_sel_o, // Address hits internal register area
    output logic internal_int_request_o, // Gated internal maskable pending
    output logic [1:0] mode_o, // Latched operating mode
    output logic mode_bad_o, // Latched mode is not allowed
    output logic reset_active_o, // Device reset in progress
    output logic as_seen_o // Address strobe level, synchronised
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic reset_n_s, nmi_n_s, ext_n_s, halt_n_s, mpl_s, mph_s;
    sync2 u_s_rst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .d_i(reset_n_i), .init_i(1'b0), .q_o(reset_n_s));
    sync2 u_s_nmi (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .d_i(nmi_n_i), .init_i(1'b1), .q_o(nmi_n_s));
    sync2 u_s_ext (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .d_i(external_int_request_n_i),
        .init_i(1'b1), .q_o(ext_n_s));
    sync2 u_s_hlt (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .d_i(halt_n_i), .init_i(1'b1), .q_o(halt_n_s));
    sync2 u_s_mpl (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .d_i(mode_pin_low_i), .init_i(1'b0), .q_o(mpl_s));
    sync2 u_s_mph (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .d_i(mode_pin_high_i), .init_i(1'b0), .q_o(mph_s));
    // Strobe is only observed; the outside party owns it
    sync2 u_s_as (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .d_i(low_address_strobe_i),
        .init_i(1'b0), .q_o(as_seen_o));

    // ------------------------------------------------------------
    // Registers over Wishbone
    // ------------------------------------------------------------
    logic [7:0] ctrl_r;
    logic step_req_r;
    logic [15:0] last_vec_r;
    logic nmi_pend_r;
    seq_state_t state_r;
    wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    wire [7:0] wb_off = wb_adr_i[7:0];
    wire wb_hit = (wb_adr_i[31:8] == 24'h000000) && ((wb_off == `CTRL_OFF) || (wb_off == `STATUS_OFF)
        || (wb_off == `STEP_OFF) || (wb_off == `VECTOR_OFF));

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
        end else if (ce_i) begin
            wb_ack_o <= wb_req && wb_hit;
            wb_err_o <= wb_req && !wb_hit;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h00000000;
        end else if (ce_i && wb_req) begin
            case (wb_off)
                `CTRL_OFF: wb_dat_o <= {24'h000000, ctrl_r};
                `STATUS_OFF: wb_dat_o <= {24'h000000, mode_bad_o, nmi_pend_r, bus_granted_o,
                    state_r, mode_o};
                `VECTOR_OFF: wb_dat_o <= {16'h0000, last_vec_r};
                default: wb_dat_o <= 32'h00000000;
            endcase
        end
    end

    // Hardware sets the mask on entry; entry wins over a software write
    logic enter_w;
    src_t src_w;
    logic [15:0] vec_w;
    always_ff @(posedge clk_i) begin
        if (rst_i || !reset_n_s) begin
            ctrl_r <= `CTRL_RESET;
        end else if (ce_i) begin
            if (wb_req && wb_hit && wb_we_i && wb_off == `CTRL_OFF && wb_sel_i[0]) begin
                ctrl_r <= wb_dat_i[7:0];
            end
            if (enter_w) begin
                ctrl_r[`CTRL_MASK_BIT] <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Reset and mode capture
    // ------------------------------------------------------------
    logic reset_n_d_r;
    logic [2:0] rst_cnt_r;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reset_n_d_r <= 1'b0;
            mode_o <= `MODE_NORAM;
            rst_cnt_r <= 3'd0;
        end else if (ce_i) begin
            reset_n_d_r <= reset_n_s;
            if (!reset_n_s && rst_cnt_r != 3'd7) begin
                rst_cnt_r <= rst_cnt_r + 3'd1;
            end else if (reset_n_s) begin
                rst_cnt_r <= 3'd0;
            end
            if (reset_n_s && !reset_n_d_r) begin
                mode_o <= {mph_s, mpl_s};
            end
        end
    end
    assign reset_active_o = !reset_n_s;
    assign mode_bad_o = (mode_o != `MODE_RAM) && (mode_o != `MODE_NORAM);

    // ------------------------------------------------------------
    // Request recognition
    // ------------------------------------------------------------
    logic nmi_n_d_r;
    logic [3:0] int_gated;
    assign int_gated[0] = capture_event_flag_i && ctrl_r[`CTRL_EN_CAP_BIT];
    assign int_gated[1] = compare_match_flag_i && ctrl_r[`CTRL_EN_CMP_BIT];
    assign int_gated[2] = counter_wrap_flag_i && ctrl_r[`CTRL_EN_WRAP_BIT];
    assign int_gated[3] = (receive_full_flag_i || overrun_framing_flag_i || transmit_empty_flag_i)
        && ctrl_r[`CTRL_EN_SER_BIT];
    assign internal_int_request_o = |int_gated;

    // Edge latch; a new edge in the clearing cycle keeps the request
    always_ff @(posedge clk_i) begin
        if (rst_i || !reset_n_s) begin
            nmi_n_d_r <= 1'b1;
            nmi_pend_r <= 1'b0;
        end else if (ce_i) begin
            nmi_n_d_r <= nmi_n_s;
            if (nmi_n_d_r && !nmi_n_s) begin
                nmi_pend_r <= 1'b1;
            end else if (enter_w && src_w == SRC_NMI) begin
                nmi_pend_r <= 1'b0;
            end
        end
    end

    vec_prio u_prio (
        .nmi_pend_i(nmi_pend_r),
        .trap_i(software_trap_i),
        .ext_i(!ext_n_s),
        .int_i(int_gated),
        .mask_i(ctrl_r[`CTRL_MASK_BIT]),
        .src_o(src_w),
        .vec_o(vec_w)
    );

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    logic [2:0] stack_cnt_r;
    wire at_boundary = (state_r == ST_RUN) && instr_done_i;
    wire stop_w = !halt_n_s && !step_req_r;
    assign enter_w = ce_i && at_boundary && !stop_w && (src_w != SRC_NONE) && reset_n_s;

    always_ff @(posedge clk_i) begin
        if (rst_i || !reset_n_s) begin
            state_r <= ST_VEC_HI;
            stack_cnt_r <= 3'd0;
            last_vec_r <= `VEC_RESET;
        end else if (ce_i) begin
            case (state_r)
                ST_RUN: begin
                    if (at_boundary && stop_w) begin
                        state_r <= ST_HALT;
                    end else if (enter_w) begin
                        state_r <= ST_STACK;
                        stack_cnt_r <= 3'd0;
                        last_vec_r <= vec_w;
                    end
                end
                ST_STACK: begin
                    stack_cnt_r <= stack_cnt_r + 3'd1;
                    if (stack_cnt_r == `STACK_BYTES - 3'd1) begin
                        state_r <= ST_VEC_HI;
                    end
                end
                ST_VEC_HI: state_r <= ST_VEC_LO;
                ST_VEC_LO: state_r <= ST_RUN;
                ST_HALT: begin
                    if (halt_n_s || step_req_r) begin
                        state_r <= ST_RUN;
                    end
                end
                default: state_r <= ST_RUN;
            endcase
        end
    end

    // A one-cycle release, or a software step, lets one instruction through
    logic halt_n_d_r;
    always_ff @(posedge clk_i) begin
        if (rst_i || !reset_n_s) begin
            step_req_r <= 1'b0;
            halt_n_d_r <= 1'b1;
        end else if (ce_i) begin
            halt_n_d_r <= halt_n_s;
            if (wb_req && wb_hit && wb_we_i && wb_off == `STEP_OFF && wb_sel_i[0] && wb_dat_i[0]) begin
                step_req_r <= 1'b1;
            end else if (at_boundary || state_r == ST_HALT) begin
                // Used up as the halt is left, so the next boundary stops again
                step_req_r <= 1'b0;
            end
        end
    end

    assign core_run_o = (state_r == ST_RUN);
    assign core_stack_o = (state_r == ST_STACK);
    assign vec_fetch_o = (state_r == ST_VEC_HI) || (state_r == ST_VEC_LO);
    assign vec_addr_o = (state_r == ST_VEC_LO) ? (last_vec_r | 16'h0001) : last_vec_r;
    assign bus_granted_o = (state_r == ST_HALT);
    assign rw_o = (state_r == ST_HALT) ? 1'b1 : (core_stack_o || (core_run_o && instr_write_i)) ? 1'b0
        : 1'b1;
    assign addr_o = (state_r == ST_HALT) ? next_addr_i : vec_fetch_o ? vec_addr_o : bus_addr_i;
    assign internal_reg_sel_o = (addr_o < 16'(`REG_AREA_SIZE)) && (addr_o[7:0] != 8'h04) && (addr_o[7:0] != 8'h05)
        && (addr_o[7:0] != 8'h06) && (addr_o[7:0] != 8'h07) && (addr_o[7:0] != 8'h0f);
endmodule : interrupt_halt_reset_control

// ---- design/sync2.sv ----
`timescale 1ns/10ps
module sync2 (
    input wire logic clk_i, // Clock
    input wire logic rst_i, // Sync reset
    input wire logic ce_i, // Clock enable
    input wire logic d_i, // Async level
    input wire logic init_i, // Reset level (constant at use)
    output logic q_o // Synchronised level
);
    logic s1_r;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_r <= init_i;
            q_o <= init_i;
        end else if (ce_i) begin
            s1_r <= d_i;
            q_o <= s1_r;
        end
    end
endmodule : sync2

// ---- design/vec_prio.sv ----
`timescale 1ns/10ps
`include "exc_cfg.svh"
module vec_prio
    import exc_pkg::*;
(
    input wire logic nmi_pend_i, // Latched non-maskable request
    input wire logic trap_i, // Software trap at boundary
    input wire logic ext_i, // External maskable level, active high
    input wire logic [3:0] int_i, // Gated internal: cap, cmp, wrap, ser
    input wire logic mask_i, // Interrupt mask bit
    output src_t src_o, // Winning source
    output logic [15:0] vec_o // Vector high-byte address
);
    always_comb begin
        src_o = SRC_NONE;
        vec_o = `VEC_RESET;
        if (nmi_pend_i) begin
            src_o = SRC_NMI;
            vec_o = `VEC_NMI;
        end else if (trap_i) begin
            src_o = SRC_TRAP;
            vec_o = `VEC_TRAP;
        end else if (!mask_i && ext_i) begin
            src_o = SRC_EXT;
            vec_o = `VEC_EXT;
        end else if (!mask_i && int_i[0]) begin
            src_o = SRC_CAP;
            vec_o = `VEC_CAP;
        end else if (!mask_i && int_i[1]) begin
            src_o = SRC_CMP;
            vec_o = `VEC_CMP;
        end else if (!mask_i && int_i[2]) begin
            src_o = SRC_WRAP;
            vec_o = `VEC_WRAP;
        end else if (!mask_i && int_i[3]) begin
            src_o = SRC_SER;
            vec_o = `VEC_SER;
        end
    end
endmodule : vec_prio
